// ### rtl/evflag_top.sv
// Event flags, masks and trigger modes for the converter and transmitter.
// Assumes synchronous event inputs and a one-cycle strobe register port.
//
// Functional notes
// - Buffer copy done sets flag if enabled
// - Both estimators fast phase done sets ready
// - Input rate above output sets ratio flag
// - Any flag drives interrupt low, summary set
// - Buffer copy mask defaults zero, masks
// - Slip mask defaults zero, masks
// - Ready and ratio masks default zero
// - Two-bit trigger mode per event
module evflag_top
	import evflag_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       tx_buffer_enable,
	input  wire logic       tx_buffer_copy_done,
	input  wire logic       async_block_start,
	input  wire logic       sync_block_start,
	input  wire logic       in_rate_fast_done,
	input  wire logic       out_rate_fast_done,
	input  wire logic       in_rate_above_out,
	output logic            int_n,
	output logic            block_start_source_select
);
	logic [7:0]            mask_reg;
	logic [7:0]            mode_reg;
	logic [7:0]            control_reg;
	logic [NUM_EVENTS-1:0] flag_reg;
	logic [NUM_EVENTS-1:0] flag_next;
	logic [NUM_EVENTS-1:0] src;
	logic [NUM_EVENTS-1:0] hit;
	logic [NUM_EVENTS-1:0] enable;
	logic [NUM_EVENTS-1:0] set;
	logic [7:0]            status_view;
	logic [7:0]            rdata_next;
	logic                  clear;

	////////////////////////////////////////////////////////////////////////
	// Event sources and qualification
	always_comb begin
		src[0] = tx_buffer_copy_done;
		src[1] = control_reg[BIT_BLOCK_SEL] ? sync_block_start : async_block_start;
		src[2] = in_rate_fast_done & out_rate_fast_done;
		src[3] = in_rate_above_out;
		enable[0] = mask_reg[BIT_BUF_COPY] & tx_buffer_enable;
		enable[1] = mask_reg[BIT_SLIP];
		enable[2] = mask_reg[BIT_READY];
		enable[3] = mask_reg[BIT_RATIO];
	end

	genvar g;
	generate
		for (g = 0; g < NUM_EVENTS; g++) begin : gen_event
			evflag_trigger u_trig (
				.clk   (clk),
				.rst_n (rst_n),
				.mode  (mode_reg[2*g+1:2*g]),
				.src   (src[g]),
				.hit   (hit[g])
			);
			assign set[g] = hit[g] & enable[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Sticky flags, cleared by reading the event status, set wins
	assign clear = rd && (addr == ADDR_EVENT_STATUS);

	always_comb begin
		flag_next = clear ? '0 : flag_reg;
		flag_next = flag_next | set;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			int_n <= 1'b1;
		end else begin
			int_n <= ~|flag_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_reg <= MASK_RESET;
		end else if (wr && addr == ADDR_INT_MASK) begin
			mask_reg <= wdata & MASK_USED;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_reg <= MODE_RESET;
		end else if (wr && addr == ADDR_INT_MODE) begin
			mode_reg <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			control_reg <= CONTROL_RESET;
		end else if (wr && addr == ADDR_TX_CONTROL) begin
			control_reg <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			block_start_source_select <= 1'b0;
		end else if (wr && addr == ADDR_TX_CONTROL) begin
			block_start_source_select <= wdata[BIT_BLOCK_SEL];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path
	always_comb begin
		status_view = '0;
		status_view[BIT_BUF_COPY] = flag_reg[0];
		status_view[BIT_SLIP]     = flag_reg[1];
		status_view[BIT_READY]    = flag_reg[2];
		status_view[BIT_RATIO]    = flag_reg[3];
		rdata_next = '0;
		if (rd) begin
			unique case (addr)
				ADDR_EVENT_STATUS:  rdata_next = status_view;
				ADDR_INT_MASK:      rdata_next = mask_reg;
				ADDR_INT_MODE:      rdata_next = mode_reg;
				ADDR_TX_CONTROL:    rdata_next = control_reg;
				ADDR_GLOBAL_STATUS: rdata_next[BIT_SUMMARY] = |flag_reg;
				default:            rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_buf_copy_set: assert property (@(posedge clk) disable iff (!rst_n)
		mask_reg[BIT_BUF_COPY] && mode_reg[1:0] == 2'h2 && tx_buffer_copy_done
		&& tx_buffer_enable |=> flag_reg[0])
		else $error("buffer copy flag not set");
	a_buf_copy_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!tx_buffer_enable && !flag_reg[0] && !clear |=> !flag_reg[0])
		else $error("buffer copy flag set while disabled");
	a_slip_select: assert property (@(posedge clk) disable iff (!rst_n)
		mask_reg[BIT_SLIP] && mode_reg[3:2] == 2'h2 && control_reg[BIT_BLOCK_SEL]
		&& sync_block_start |=> flag_reg[1])
		else $error("slip flag missed selected source");
	a_ready_both: assert property (@(posedge clk) disable iff (!rst_n)
		!(in_rate_fast_done && out_rate_fast_done) && !flag_reg[2]
		&& mode_reg[5:4] != 2'h1 |=> !flag_reg[2])
		else $error("ready flag set before both estimators");
	a_ratio_rise: assert property (@(posedge clk) disable iff (!rst_n)
		mask_reg[BIT_RATIO] && mode_reg[7:6] == 2'h0 && $rose(in_rate_above_out)
		|=> flag_reg[3])
		else $error("ratio flag missed rising edge");
	a_int_follow: assert property (@(posedge clk) disable iff (!rst_n)
		(|set) |=> !int_n)
		else $error("interrupt output not low after a set");
	a_mask_block: assert property (@(posedge clk) disable iff (!rst_n)
		!mask_reg[BIT_SLIP] && !flag_reg[1] |=> !flag_reg[1])
		else $error("masked slip flag was set");
	a_mask_layout: assert property (@(posedge clk) disable iff (!rst_n)
		rd && addr == ADDR_INT_MASK |=> rdata[7:6] == 2'h0 && rdata[3:2] == 2'h0)
		else $error("unused mask bits read nonzero");
	a_status_ro: assert property (@(posedge clk) disable iff (!rst_n)
		wr && addr == ADDR_EVENT_STATUS && set == '0 |=> flag_reg == $past(flag_reg))
		else $error("status register changed by write");
	a_mode_reserved: assert property (@(posedge clk) disable iff (!rst_n)
		mode_reg[5:4] == 2'h3 |-> !hit[2])
		else $error("reserved mode produced a trigger");
	a_copy_reserved: assert property (@(posedge clk) disable iff (!rst_n)
		mode_reg[1:0] == 2'h3 |-> !hit[0])
		else $error("reserved copy mode produced a trigger");
	a_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
		wr && addr == ADDR_INT_MODE |=> mode_reg == $past(wdata))
		else $error("mode register write lost");
	a_ready_fall: assert property (@(posedge clk) disable iff (!rst_n)
		mask_reg[BIT_READY] && mode_reg[5:4] == 2'h1
		&& $fell(in_rate_fast_done && out_rate_fast_done) |=> flag_reg[2])
		else $error("ready flag missed falling edge");
	a_ratio_level: assert property (@(posedge clk) disable iff (!rst_n)
		mask_reg[BIT_RATIO] && mode_reg[7:6] == 2'h2 && in_rate_above_out |=> flag_reg[3])
		else $error("ratio flag missed level");
	a_int_idle: assert property (@(posedge clk) disable iff (!rst_n)
		flag_reg == '0 && set == '0 |=> int_n)
		else $error("interrupt low with no flag");
	a_summary_read: assert property (@(posedge clk) disable iff (!rst_n)
		rd && addr == ADDR_GLOBAL_STATUS && flag_reg != '0 |=> rdata[BIT_SUMMARY])
		else $error("summary bit clear with flags set");
	a_status_layout: assert property (@(posedge clk) disable iff (!rst_n)
		rd && addr == ADDR_EVENT_STATUS |=> rdata[7:6] == 2'h0 && rdata[3:2] == 2'h0)
		else $error("unused status bits read nonzero");
	a_mask_reset: assert property (@(posedge clk)
		!rst_n |=> mask_reg == MASK_RESET && mode_reg == MODE_RESET)
		else $error("mask or mode not cleared by reset");
endmodule

// ### inc/evflag_pkg.sv
// Constants for the converter and transmitter event flag block.
// Assumes an 8-bit host register port with an 8-bit address.
package evflag_pkg;
	localparam logic [7:0] ADDR_GLOBAL_STATUS = 8'h02;
	localparam logic [7:0] ADDR_TX_CONTROL    = 8'h07;
	localparam logic [7:0] ADDR_EVENT_STATUS  = 8'h0a;
	localparam logic [7:0] ADDR_INT_MASK      = 8'h0b;
	localparam logic [7:0] ADDR_INT_MODE      = 8'h0c;
	localparam int         BIT_BUF_COPY       = 0;
	localparam int         BIT_SLIP           = 1;
	localparam int         BIT_READY          = 4;
	localparam int         BIT_RATIO          = 5;
	localparam int         BIT_SUMMARY        = 1;
	localparam int         BIT_BLOCK_SEL      = 0;
	localparam int         NUM_EVENTS         = 4;
	localparam logic [7:0] MASK_RESET         = 8'h00;
	localparam logic [7:0] MODE_RESET         = 8'h00;
	localparam logic [7:0] CONTROL_RESET      = 8'h00;
	localparam logic [7:0] MASK_USED          = 8'h33;
	typedef enum logic [1:0] {
		TRIG_RISE  = 2'h0,
		TRIG_FALL  = 2'h1,
		TRIG_LEVEL = 2'h2,
		TRIG_RSVD  = 2'h3
	} trig_mode_t;
endpackage

// ### rtl/evflag_trigger.sv
// One event trigger detector: edge or level qualification of a source.
// Assumes the source is synchronous to clk.
module evflag_trigger
	import evflag_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] mode,
	input  wire logic       src,
	output logic            hit
);
	logic prev_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= src;
		end
	end

	always_comb begin
		unique case (trig_mode_t'(mode))
			TRIG_RISE:  hit = src & ~prev_reg;
			TRIG_FALL:  hit = ~src & prev_reg;
			TRIG_LEVEL: hit = src;
			TRIG_RSVD:  hit = 1'b0;
		endcase
	end
endmodule

// ### bench/evflag_top_tb.sv
// Self-checking testbench for the event flag block.
// Assumes the package is compiled first; the bench drives every port itself.
module evflag_top_tb
	import evflag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic       en = 1'b0;
	logic [5:0] src = 6'h00;
	logic       int_n;
	logic       bss;
	int         miscompares = 0;
	int         num_checks = 0;
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #10 clk = ~clk;
	end
	evflag_top dut (
		.clk                       (clk),
		.rst_n                     (rst_n),
		.addr                      (addr),
		.wdata                     (wdata),
		.wr                        (wr),
		.rd                        (rd),
		.rdata                     (rdata),
		.tx_buffer_enable          (en),
		.tx_buffer_copy_done       (src[0]),
		.async_block_start         (src[1]),
		.sync_block_start          (src[2]),
		.in_rate_fast_done         (src[3]),
		.out_rate_fast_done        (src[4]),
		.in_rate_above_out         (src[5]),
		.int_n                     (int_n),
		.block_start_source_select (bss)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic go(input logic [5:0] v, input logic e);
		@(posedge clk);
		src <= v;
		en <= e;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({6'h00, bss, int_n}, 8'h01);
		rd_chk(ADDR_INT_MASK, 8'h00);
		rd_chk(ADDR_INT_MODE, 8'h00);
		go(6'h3f, 1'b1);
		rd_chk(ADDR_EVENT_STATUS, 8'h00);
		chk({7'h00, int_n}, 8'h01);
		go(6'h00, 1'b0);
		$display("test reset and masking done");
		wr_reg(ADDR_INT_MASK, 8'hff);
		rd_chk(ADDR_INT_MASK, 8'h33);
		go(6'h18, 1'b0);
		chk({7'h00, int_n}, 8'h00);
		rd_chk(ADDR_GLOBAL_STATUS, 8'h02);
		rd_chk(ADDR_EVENT_STATUS, 8'h10);
		rd_chk(ADDR_EVENT_STATUS, 8'h00);
		chk({7'h00, int_n}, 8'h01);
		go(6'h08, 1'b0);
		go(6'h28, 1'b0);
		rd_chk(ADDR_EVENT_STATUS, 8'h20);
		$display("test ready and ratio done");
		go(6'h2a, 1'b0);
		rd_chk(ADDR_EVENT_STATUS, 8'h02);
		wr_reg(ADDR_TX_CONTROL, 8'h01);
		rd_chk(ADDR_TX_CONTROL, 8'h01);
		go(6'h28, 1'b0);
		chk({7'h00, bss}, 8'h01);
		go(6'h2a, 1'b0);
		rd_chk(ADDR_EVENT_STATUS, 8'h00);
		go(6'h2e, 1'b0);
		rd_chk(ADDR_EVENT_STATUS, 8'h02);
		$display("test slip done");
		go(6'h2f, 1'b0);
		rd_chk(ADDR_EVENT_STATUS, 8'h00);
		go(6'h2e, 1'b1);
		go(6'h2f, 1'b1);
		rd_chk(ADDR_EVENT_STATUS, 8'h01);
		$display("test copy done");
		wr_reg(ADDR_INT_MODE, 8'h01);
		go(6'h2e, 1'b1);
		rd_chk(ADDR_EVENT_STATUS, 8'h01);
		wr_reg(ADDR_INT_MODE, 8'h02);
		go(6'h2f, 1'b1);
		rd_chk(ADDR_EVENT_STATUS, 8'h01);
		rd_chk(ADDR_EVENT_STATUS, 8'h01);
		wr_reg(ADDR_INT_MODE, 8'h03);
		rd_chk(ADDR_EVENT_STATUS, 8'h01);
		go(6'h2e, 1'b1);
		go(6'h2f, 1'b1);
		rd_chk(ADDR_EVENT_STATUS, 8'h00);
		$display("test trigger modes done");
		wr_reg(ADDR_EVENT_STATUS, 8'hff);
		rd_chk(ADDR_EVENT_STATUS, 8'h00);
		$display("test read-only status done");
		wr_reg(ADDR_INT_MODE, 8'h98);
		rd_chk(ADDR_EVENT_STATUS, 8'h22);
		rd_chk(ADDR_EVENT_STATUS, 8'h22);
		go(6'h1b, 1'b1);
		rd_chk(ADDR_EVENT_STATUS, 8'h22);
		rd_chk(ADDR_EVENT_STATUS, 8'h00);
		go(6'h13, 1'b1);
		chk({7'h00, int_n}, 8'h00);
		rd_chk(ADDR_EVENT_STATUS, 8'h10);
		wr_reg(ADDR_INT_MODE, 8'h30);
		go(6'h1b, 1'b1);
		go(6'h13, 1'b1);
		rd_chk(ADDR_EVENT_STATUS, 8'h00);
		$display("test level and falling modes done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({6'h00, bss, int_n}, 8'h01);
		rd_chk(ADDR_INT_MASK, 8'h00);
		rd_chk(ADDR_EVENT_STATUS, 8'h00);
		$display("test second reset done");
		final_report();
	end
endmodule
